// file: common/pdd_params.svh
// Timing, widths and transfer limits for the paced digital I/O DMA stream block.
// Assumes inclusion by bare name from design and bench files alike.
`ifndef PDD_PARAMS_SVH
`define PDD_PARAMS_SVH
`define PDD_CLK_HZ 25000000
`define PDD_BASE_HZ 4000000
`define PDD_ACC_W 25
`define PDD_DIV_W 16
`define PDD_DIV_MIN 16'h0002
`define PDD_BYTE_W 27
`define PDD_MAX_BYTES 27'h4000000
`define PDD_WORD_W 25
`define PDD_ADDR_W 32
`define PDD_CNT_W 32
`define PDD_WORD_SHIFT 2
`endif

// file: common/pdd_pkg.sv
// Types shared by the paced digital I/O DMA stream block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pdd_pkg;
  typedef enum logic [1:0] {
    PDD_DI_PACER = 2'b00,
    PDD_DI_RISE = 2'b01,
    PDD_DI_FALL = 2'b10,
    PDD_DI_HSHAKE = 2'b11
  } pdd_di_mode_t;
  typedef enum logic [1:0] {
    PDD_DO_PACER = 2'b00,
    PDD_DO_GATED = 2'b01,
    PDD_DO_HSHAKE = 2'b10,
    PDD_DO_SPARE = 2'b11
  } pdd_do_mode_t;
  typedef enum logic [1:0] {
    PDD_OUT_IDLE = 2'b00,
    PDD_OUT_FETCH = 2'b01,
    PDD_OUT_HOLD = 2'b10
  } pdd_out_state_t;
endpackage : pdd_pkg
`default_nettype wire

// file: hdl/pdd_divider.sv
// One pacer counter: emits one pulse per div_i input ticks.
// Assumes div_i is held stable while running and is at least two.
`timescale 1ns/1ps
`include "pdd_params.svh"
`default_nettype none
module pdd_divider #(
  parameter int DIV_W = `PDD_DIV_W
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic tick_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic tick_o
);
  logic [DIV_W-1:0] cnt;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if (cnt <= DIV_W'(1)) begin
          cnt <= div_i;
          tick_o <= 1'b1;
        end else begin
          cnt <= cnt - DIV_W'(1);
        end
      end
    end
  end
endmodule : pdd_divider
`default_nettype wire

// file: hdl/pdd_top.sv
// Paced digital input and output engines moving 32-bit samples to and from host memory.
// Assumes a simple word master port to host memory with one-cycle acknowledge pulses.
// What this block does
// RULE1: Uncascaded input pacer ticks at the 4 MHz base divided by counter zero.
// RULE2: Cascaded input pacer ticks at base divided by counter zero times counter two.
// RULE3: Software loads each divider with a value from 2 to 65535.
// RULE4: Cascaded output pacer ticks at base divided by counter one times counter two.
// RULE5: Output modes: timer paced, timer gated by output request, or handshake.
// RULE6: Output moves a sample count until done or stopped.
// RULE7: Repeat replays the buffer until stopped; otherwise output runs once.
// RULE8: Output reports run flag, 1 busy and 0 done, plus samples moved.
// RULE9: Output sample count stays readable after stop or terminal count.
// RULE10: Software places all DMA buffers on double-word aligned addresses.
// RULE11: Double-buffer input treats memory as a ring of two equal halves.
// RULE12: Double-buffer input fills first half, second half, then wraps endlessly.
// RULE13: Half-ready rises whenever one half is completely filled.
// RULE14: Overrun count increments when an uncollected full half is overwritten.
// RULE15: Input clocked by pacer, strobe or handshake; only handshake throttles source.
// RULE16: One transfer is at most 64 MB; only the input byte count is clamped, the output sample count is not limited.
// RULE17: Two-bit input mode: pacer, rising request, falling request, handshake.
// RULE18: Transfers move whole 32-bit words, byte count up to 2^26.
// RULE19: Optionally input sampling stops at DMA completion, else it continues.
// RULE20: Half-ready clears once collected and sets again when the other half fills.
`timescale 1ns/1ps
`include "pdd_params.svh"
`default_nettype none
module pdd_top #(
  parameter int DIV_W = `PDD_DIV_W,
  parameter int BYTE_W = `PDD_BYTE_W
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [DIV_W-1:0] pacer_counter_zero_i,
  input wire logic [DIV_W-1:0] pacer_counter_one_i,
  input wire logic [DIV_W-1:0] cascade_counter_two_i,
  input wire logic di_chained_divider_setting_i,
  input wire logic do_chained_divider_setting_i,
  input wire logic di_start_i,
  input wire logic di_stop_i,
  input wire pdd_pkg::pdd_di_mode_t di_mode_i,
  input wire logic di_dbuf_i,
  input wire logic di_stop_on_done_i,
  input wire logic [`PDD_ADDR_W-1:0] di_base_i,
  input wire logic [BYTE_W-1:0] di_bytes_i,
  input wire logic di_collect_i,
  input wire logic [31:0] di_data_i,
  input wire logic di_req_i,
  output logic di_ack_o,
  output logic di_run_o,
  output logic [`PDD_CNT_W-1:0] di_count_o,
  output logic di_half_ready_o,
  output logic di_ready_half_o,
  output logic [`PDD_CNT_W-1:0] di_overrun_o,
  output logic wr_req_o,
  output logic [`PDD_ADDR_W-1:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  input wire logic wr_ack_i,
  input wire logic do_start_i,
  input wire logic do_stop_i,
  input wire pdd_pkg::pdd_do_mode_t do_mode_i,
  input wire logic do_repeat_i,
  input wire logic [`PDD_ADDR_W-1:0] do_base_i,
  input wire logic [`PDD_WORD_W-1:0] do_samples_i,
  input wire logic do_req_i,
  output logic do_ack_o,
  output logic [31:0] do_data_o,
  output logic do_run_o,
  output logic [`PDD_CNT_W-1:0] do_count_o,
  output logic rd_req_o,
  output logic [`PDD_ADDR_W-1:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_ack_i
);
  // ----------------------------------------------------------------
  // Base clock and pacers
  // ----------------------------------------------------------------
  logic [`PDD_ACC_W-1:0] acc;
  logic base_tick, c2_tick, c0_tick, c1_tick;

  // Fractional accumulator averages exactly the base rate
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      acc <= '0;
      base_tick <= 1'b0;
    end else if (acc >= `PDD_ACC_W'(`PDD_CLK_HZ - `PDD_BASE_HZ)) begin
      acc <= acc - `PDD_ACC_W'(`PDD_CLK_HZ - `PDD_BASE_HZ);
      base_tick <= 1'b1;
    end else begin
      acc <= acc + `PDD_ACC_W'(`PDD_BASE_HZ);
      base_tick <= 1'b0;
    end
  end

  pdd_divider #(.DIV_W(DIV_W)) u_c2 (.mclk_i(mclk_i), .srst_i(srst_i), .tick_i(base_tick),
    .div_i(cascade_counter_two_i), .tick_o(c2_tick));
  pdd_divider #(.DIV_W(DIV_W)) u_c0 (.mclk_i(mclk_i), .srst_i(srst_i), // [RULE1] [RULE2]
    .tick_i(di_chained_divider_setting_i ? c2_tick : base_tick), .div_i(pacer_counter_zero_i), .tick_o(c0_tick));
  pdd_divider #(.DIV_W(DIV_W)) u_c1 (.mclk_i(mclk_i), .srst_i(srst_i), // [RULE4]
    .tick_i(do_chained_divider_setting_i ? c2_tick : base_tick), .div_i(pacer_counter_one_i), .tick_o(c1_tick));

  // Word count from a byte count, clamped to the largest transfer
  function automatic logic [`PDD_WORD_W-1:0] words_of(input logic [BYTE_W-1:0] b);
    logic [BYTE_W-1:0] lim;
    lim = (b > BYTE_W'(`PDD_MAX_BYTES)) ? BYTE_W'(`PDD_MAX_BYTES) : b; // [RULE16]
    words_of = `PDD_WORD_W'(lim >> `PDD_WORD_SHIFT); // [RULE18]
  endfunction : words_of

  function automatic logic [`PDD_ADDR_W-1:0] addr_of(input logic [`PDD_ADDR_W-1:0] base,
                                                     input logic [`PDD_WORD_W-1:0] idx);
    addr_of = base + (`PDD_ADDR_W'(idx) << `PDD_WORD_SHIFT); // [RULE10]
  endfunction : addr_of

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  logic req_q, sampling, held, di_event;
  logic [`PDD_WORD_W-1:0] di_words, di_idx;
  logic [1:0] pend;
  logic next_half;

  always_comb begin
    unique case (di_mode_i) // [RULE15] [RULE17]
      pdd_pkg::PDD_DI_PACER: di_event = c0_tick;
      pdd_pkg::PDD_DI_RISE: di_event = di_req_i & ~req_q;
      pdd_pkg::PDD_DI_FALL: di_event = ~di_req_i & req_q;
      pdd_pkg::PDD_DI_HSHAKE: di_event = di_req_i & ~held & ~di_ack_o;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      req_q <= 1'b0;
    end else begin
      req_q <= di_req_i;
    end
  end

  // Handshake acknowledge only when a slot is free, so the source waits
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      di_ack_o <= 1'b0;
    end else begin
      di_ack_o <= sampling && di_mode_i == pdd_pkg::PDD_DI_HSHAKE && di_event; // [RULE15]
    end
  end

  // ----------------------------------------------------------------
  // Input DMA
  // ----------------------------------------------------------------
  assign wr_req_o = held;
  assign next_half = (di_idx + `PDD_WORD_W'(1)) == (di_words >> 1);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sampling <= 1'b0;
      di_run_o <= 1'b0;
      held <= 1'b0;
      di_idx <= '0;
      di_words <= '0;
      di_count_o <= '0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
    end else if (di_start_i) begin
      sampling <= 1'b1;
      di_run_o <= 1'b1;
      held <= 1'b0;
      di_idx <= '0;
      di_words <= words_of(di_bytes_i);
      di_count_o <= '0;
    end else if (di_stop_i) begin
      sampling <= 1'b0;
      di_run_o <= 1'b0;
      held <= 1'b0;
    end else begin
      // Pacer and strobe samples that find the slot busy are dropped
      if (sampling && di_run_o && di_event && !held) begin
        held <= 1'b1;
        wr_data_o <= di_data_i;
        wr_addr_o <= addr_of(di_base_i, di_idx);
      end
      if (held && wr_ack_i) begin
        held <= 1'b0;
        di_count_o <= di_count_o + `PDD_CNT_W'(1);
        if (di_idx + `PDD_WORD_W'(1) == di_words) begin
          di_idx <= '0; // [RULE12]
          if (!di_dbuf_i) begin
            di_run_o <= 1'b0;
            if (di_stop_on_done_i) begin
              sampling <= 1'b0; // [RULE19]
            end
          end
        end else begin
          di_idx <= di_idx + `PDD_WORD_W'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Double buffer halves
  // ----------------------------------------------------------------
  logic fill_done, half_done;
  logic [1:0] next_pend;
  assign half_done = held && wr_ack_i && di_dbuf_i && next_half; // [RULE11]
  assign fill_done = held && wr_ack_i && di_dbuf_i && (di_idx + `PDD_WORD_W'(1) == di_words);

  always_comb begin
    next_pend = pend;
    if (di_collect_i) begin
      next_pend[di_ready_half_o] = 1'b0; // [RULE20]
    end
    if (half_done) begin
      next_pend[0] = 1'b1; // [RULE13]
    end
    if (fill_done) begin
      next_pend[1] = 1'b1; // [RULE13]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || di_start_i) begin
      pend <= '0;
      di_overrun_o <= '0;
    end else begin
      pend <= next_pend;
      if ((half_done && pend[0] && !(di_collect_i && !di_ready_half_o)) ||
          (fill_done && pend[1] && !(di_collect_i && di_ready_half_o))) begin
        di_overrun_o <= di_overrun_o + `PDD_CNT_W'(1); // [RULE14]
      end
    end
  end

  // With both halves pending, the second half is offered first
  always_ff @(posedge mclk_i) begin
    if (srst_i || di_start_i) begin
      di_ready_half_o <= 1'b0;
    end else if (next_pend == 2'b10 || (next_pend == 2'b11 && fill_done && !pend[1])) begin
      di_ready_half_o <= 1'b1;
    end else if (next_pend != 2'b11) begin
      di_ready_half_o <= 1'b0;
    end
  end

  assign di_half_ready_o = |pend; // [RULE13] [RULE20]

  // ----------------------------------------------------------------
  // Output engine
  // ----------------------------------------------------------------
  pdd_pkg::pdd_out_state_t ost;
  logic [`PDD_WORD_W-1:0] do_idx, do_total;
  logic [31:0] do_buf;
  logic do_event;

  always_comb begin
    unique case (do_mode_i) // [RULE5]
      pdd_pkg::PDD_DO_PACER: do_event = c1_tick;
      pdd_pkg::PDD_DO_GATED: do_event = c1_tick & do_req_i;
      pdd_pkg::PDD_DO_HSHAKE: do_event = do_req_i;
      default: do_event = 1'b0;
    endcase
  end

  assign rd_req_o = (ost == pdd_pkg::PDD_OUT_FETCH);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ost <= pdd_pkg::PDD_OUT_IDLE;
      do_run_o <= 1'b0;
      do_idx <= '0;
      do_total <= '0;
      do_count_o <= '0;
      do_buf <= '0;
      do_data_o <= '0;
      do_ack_o <= 1'b0;
      rd_addr_o <= '0;
    end else begin
      do_ack_o <= 1'b0;
      if (do_start_i && do_samples_i != '0) begin
        ost <= pdd_pkg::PDD_OUT_FETCH;
        do_run_o <= 1'b1; // [RULE8]
        do_idx <= '0;
        do_total <= do_samples_i; // [RULE6]
        do_count_o <= '0;
        rd_addr_o <= do_base_i;
      end else if (do_stop_i) begin
        ost <= pdd_pkg::PDD_OUT_IDLE;
        do_run_o <= 1'b0; // [RULE9]
      end else begin
        unique case (ost)
          pdd_pkg::PDD_OUT_IDLE: begin
          end
          pdd_pkg::PDD_OUT_FETCH: begin
            if (rd_ack_i) begin
              do_buf <= rd_data_i;
              ost <= pdd_pkg::PDD_OUT_HOLD;
            end
          end
          pdd_pkg::PDD_OUT_HOLD: begin
            if (do_event) begin
              do_data_o <= do_buf;
              do_ack_o <= (do_mode_i == pdd_pkg::PDD_DO_HSHAKE);
              do_count_o <= do_count_o + `PDD_CNT_W'(1); // [RULE8]
              if (do_idx + `PDD_WORD_W'(1) == do_total) begin
                if (do_repeat_i) begin
                  do_idx <= '0; // [RULE7]
                  rd_addr_o <= do_base_i;
                  ost <= pdd_pkg::PDD_OUT_FETCH;
                end else begin
                  ost <= pdd_pkg::PDD_OUT_IDLE; // [RULE7]
                  do_run_o <= 1'b0; // [RULE6] [RULE9]
                end
              end else begin
                do_idx <= do_idx + `PDD_WORD_W'(1);
                rd_addr_o <= addr_of(do_base_i, do_idx + `PDD_WORD_W'(1));
                ost <= pdd_pkg::PDD_OUT_FETCH;
              end
            end
          end
          default: ost <= pdd_pkg::PDD_OUT_IDLE;
        endcase
      end
    end
  end
endmodule : pdd_top
`default_nettype wire

// file: dv/pdd_props.sv
// Port checker for the pdd_top memory masters and output engine.
// Assumes it is bound into every pdd_top instance.
`timescale 1ns/1ps
`include "pdd_params.svh"
`default_nettype none
module pdd_props #(
  parameter int DIV_W = `PDD_DIV_W,
  parameter int BYTE_W = `PDD_BYTE_W
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic di_ack_o,
  input wire logic wr_req_o,
  input wire logic [`PDD_ADDR_W-1:0] wr_addr_o,
  input wire logic [31:0] wr_data_o,
  input wire logic wr_ack_i,
  input wire logic rd_req_o,
  input wire logic [`PDD_ADDR_W-1:0] rd_addr_o,
  input wire logic do_start_i,
  input wire logic do_stop_i,
  input wire logic [`PDD_WORD_W-1:0] do_samples_i,
  input wire logic do_run_o,
  input wire logic [`PDD_CNT_W-1:0] do_count_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // ------------
  // Properties
  // ------------
  wr_hold_a: assert property (wr_req_o && !wr_ack_i |=> $stable({wr_req_o, wr_addr_o, wr_data_o}))
    else $error("write request moved before accept");
  wr_drop_a: assert property (wr_req_o && wr_ack_i |=> !wr_req_o)
    else $error("write request held after accept");
  word_align_a: assert property ((wr_req_o |-> wr_addr_o[1:0] == 2'h0) and (rd_req_o |-> rd_addr_o[1:0] == 2'h0))
    else $error("memory address not word aligned");
  out_start_a: assert property (do_start_i && do_samples_i != 25'h0 |=> do_run_o)
    else $error("output run flag missing after start");
  out_stop_a: assert property (do_stop_i && !do_start_i |=> !do_run_o)
    else $error("output still running after stop");
  count_keep_a: assert property (!do_run_o && !do_start_i |=> $stable(do_count_o))
    else $error("output count moved while idle");
  count_step_a: assert property (do_run_o && !do_start_i |=> do_count_o - $past(do_count_o) <= 32'h1)
    else $error("output count jumped");
  in_ack_a: assert property (di_ack_o |=> !di_ack_o)
    else $error("input acknowledge longer than one cycle");
  cover property (wr_req_o && wr_ack_i);
  cover property ($fell(do_run_o));
  cover property (di_ack_o);
endmodule : pdd_props
bind pdd_top pdd_props #(.DIV_W(DIV_W), .BYTE_W(BYTE_W)) u_props (.*);
`default_nettype wire

// file: dv/pdd_host_mem.sv
// Host memory model: 64-word store answering the block's read and write masters.
// Assumes word addresses inside its window; lat_i sets the answer delay.
`timescale 1ns/1ps
`default_nettype none
module pdd_host_mem (
  input wire logic clk_i,
  input wire logic [3:0] lat_i,
  input wire logic wr_req_i,
  input wire logic [31:0] wr_addr_i,
  input wire logic [31:0] wr_data_i,
  output logic wr_ack_o,
  input wire logic rd_req_i,
  input wire logic [31:0] rd_addr_i,
  output logic [31:0] rd_data_o,
  output logic rd_ack_o
);
  logic [31:0] mem [0:63];
  logic [3:0] wn = 4'h0;
  logic [3:0] rn = 4'h0;
  initial begin
    wr_ack_o = 1'h0;
    rd_ack_o = 1'h0;
    rd_data_o = 32'h0;
  end
  // Whole words only, one-cycle accept after the chosen delay
  always @(posedge clk_i) begin
    wr_ack_o <= 1'h0;
    rd_ack_o <= 1'h0;
    rd_data_o <= ~rd_data_o;
    wn <= (wr_req_i && !wr_ack_o) ? wn + 4'h1 : 4'h0;
    rn <= (rd_req_i && !rd_ack_o) ? rn + 4'h1 : 4'h0;
    if (wr_req_i && !wr_ack_o && wn >= lat_i) begin
      mem[wr_addr_i[7:2]] <= wr_data_i;
      wr_ack_o <= 1'h1;
    end
    if (rd_req_i && !rd_ack_o && rn >= lat_i) begin
      rd_data_o <= mem[rd_addr_i[7:2]];
      rd_ack_o <= 1'h1;
    end
  end
endmodule : pdd_host_mem
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for pdd_top against a host memory model.
// Assumes default divider and byte-count widths.
`timescale 1ns/1ps
`include "pdd_params.svh"
`default_nettype none
module testbench;
  logic mclk_i = 1'h0, srst_i = 1'h1;
  logic [15:0] pacer_counter_zero_i = 16'ha, pacer_counter_one_i = 16'hc, cascade_counter_two_i = 16'h4;
  logic di_chained_divider_setting_i = 1'h0, do_chained_divider_setting_i = 1'h0, di_start_i = 1'h0;
  logic di_stop_i = 1'h0, di_dbuf_i = 1'h0, di_stop_on_done_i = 1'h1, di_collect_i = 1'h0, di_req_i = 1'h0;
  pdd_pkg::pdd_di_mode_t di_mode_i = pdd_pkg::PDD_DI_PACER;
  pdd_pkg::pdd_do_mode_t do_mode_i = pdd_pkg::PDD_DO_PACER;
  logic [31:0] di_base_i = 32'h80, do_base_i = 32'h0, di_data_i = 32'h0;
  logic [26:0] di_bytes_i = 27'h10;
  logic [24:0] do_samples_i = 25'h4;
  logic do_start_i = 1'h0, do_stop_i = 1'h0, do_repeat_i = 1'h0, do_req_i = 1'h0;
  logic di_ack_o, di_run_o, di_half_ready_o, di_ready_half_o, wr_req_o, wr_ack_i, do_ack_o, do_run_o, rd_req_o, rd_ack_i;
  logic [31:0] di_count_o, di_overrun_o, wr_addr_o, wr_data_o, do_data_o, do_count_o, rd_addr_o, rd_data_i;
  logic [3:0] lat = 4'h0;
  logic hs = 1'h0;
  int fail_count = 0, tests_run = 0, now = 0, tgt = 0;
  pdd_top uut (.*);
  pdd_host_mem hm (.clk_i(mclk_i), .lat_i(lat), .wr_req_i(wr_req_o), .wr_addr_i(wr_addr_o), .wr_data_i(wr_data_o),
    .wr_ack_o(wr_ack_i), .rd_req_i(rd_req_o), .rd_addr_i(rd_addr_o), .rd_data_o(rd_data_i), .rd_ack_o(rd_ack_i));
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) now <= now + 1;
  // ----------
  // Helpers
  // ----------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  task automatic pls(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
  endtask : pls
  function automatic bit cnd(input int k);
    case (k)
      0: return do_run_o === 1'h0;
      1: return di_run_o === 1'h0;
      2: return do_ack_o === 1'h1;
      3: return do_count_o === tgt;
      4: return di_count_o === tgt;
      default: return wr_req_o === 1'h0;
    endcase
  endfunction : cnd
  task automatic w(input int k, input int n);
    int i;
    for (i = 0; i < n && !cnd(k); i++) cyc(1);
    if (i == n) begin
      chk("wait", 32'h0, 32'h1);
      finish_test;
    end
  endtask : w
  // Two-sample gap is div * 25 / 2 clocks for a 4 MHz base
  task automatic rate(input int k, input int div);
    int t0;
    tgt = 1;
    w(k, 3000);
    t0 = now;
    tgt = 3;
    w(k, 3000);
    chk("rate", 32'((now - t0) >= div * 25 / 2 - 3 && (now - t0) <= div * 25 / 2 + 3), 32'h1);
  endtask : rate
  task automatic smp(input int n);
    repeat (n) begin
      di_data_i = di_data_i + 32'h1;
      di_req_i = ~di_req_i;
      cyc(2);
      di_req_i = ~di_req_i;
      cyc(3);
      w(5, 50);
    end
  endtask : smp
  // ----------
  // Scenarios
  // ----------
  task automatic t_out_pace;
    for (int c = 0; c < 2; c++) begin
      do_chained_divider_setting_i = c[0];
      pacer_counter_one_i = c[0] ? 16'h3 : 16'hc;
      pls(do_start_i);
      chk("do_run", do_run_o, 32'h1);
      rate(3, 12);
      w(0, 3000);
      chk("do_count", do_count_o, 32'h4);
      chk("do_data", do_data_o, 32'ha5000003);
    end
    do_repeat_i = 1'h1;
    do_samples_i = 25'h2;
    pls(do_start_i);
    tgt = 5;
    w(3, 4000);
    pls(do_stop_i);
    chk("do_run", do_run_o, 32'h0);
    chk("do_data", do_data_o, 32'ha5000000);
    cyc(200);
    chk("do_count", do_count_o, 32'h5);
    do_repeat_i = 1'h0;
    $display("t_out_pace done");
  endtask : t_out_pace
  task automatic t_out_req;
    do_mode_i = pdd_pkg::PDD_DO_GATED;
    pls(do_start_i);
    cyc(300);
    chk("do_count", do_count_o, 32'h0);
    do_req_i = 1'h1;
    w(0, 2000);
    chk("do_count", do_count_o, 32'h2);
    do_mode_i = pdd_pkg::PDD_DO_HSHAKE;
    do_req_i = 1'h0;
    pls(do_start_i);
    for (int i = 0; i < 2; i++) begin
      cyc(20);
      chk("do_count", do_count_o, i);
      do_req_i = 1'h1;
      w(2, 50);
      chk("do_data", do_data_o, 32'ha5000000 + i);
      do_req_i = 1'h0;
    end
    do_mode_i = pdd_pkg::PDD_DO_SPARE;
    do_req_i = 1'h1;
    pls(do_start_i);
    cyc(300);
    chk("do_count", do_count_o, 32'h0);
    pls(do_stop_i);
    do_req_i = 1'h0;
    $display("t_out_req done");
  endtask : t_out_req
  task automatic t_in_pace;
    for (int c = 0; c < 2; c++) begin
      di_chained_divider_setting_i = c[0];
      pacer_counter_zero_i = c[0] ? 16'h2 : 16'ha;
      cascade_counter_two_i = 16'h5;
      di_data_i = 32'h5a000000 + c;
      pls(di_start_i);
      rate(4, 10);
      w(1, 3000);
      chk("di_word", hm.mem[35], di_data_i);
      cyc(300);
      chk("di_count", di_count_o, 32'h4);
    end
    $display("t_in_pace done");
  endtask : t_in_pace
  task automatic t_in_ring;
    di_dbuf_i = 1'h1;
    di_mode_i = pdd_pkg::PDD_DI_RISE;
    di_data_i = 32'h0;
    pls(di_start_i);
    smp(2);
    chk("half_rdy", di_half_ready_o, 32'h1);
    chk("half_sel", di_ready_half_o, 32'h0);
    pls(di_collect_i);
    chk("half_rdy", di_half_ready_o, 32'h0);
    smp(2);
    chk("half_sel", di_ready_half_o, 32'h1);
    pls(di_collect_i);
    smp(1);
    chk("wrap", hm.mem[32], 32'h5);
    smp(5);
    chk("overrun", di_overrun_o, 32'h1);
    pls(di_stop_i);
    di_dbuf_i = 1'h0;
    $display("t_in_ring done");
  endtask : t_in_ring
  task automatic t_in_modes;
    di_mode_i = pdd_pkg::PDD_DI_FALL;
    di_req_i = 1'h1;
    di_bytes_i = 27'h8;
    pls(di_start_i);
    smp(2);
    chk("di_count", di_count_o, 32'h2);
    chk("di_run", di_run_o, 32'h0);
    di_mode_i = pdd_pkg::PDD_DI_HSHAKE;
    di_bytes_i = 27'h10;
    lat = 4'h5;
    hs = 1'h1;
    di_data_i = 32'h70;
    pls(di_start_i);
    w(1, 500);
    for (int i = 0; i < 4; i++) chk("hs_word", hm.mem[32 + i], 32'h70 + i);
    cyc(30);
    chk("hs_stop", di_data_i, 32'h74);
    di_stop_on_done_i = 1'h0;
    pls(di_start_i);
    w(1, 500);
    cyc(30);
    chk("hs_more", 32'(di_data_i > 32'h7e), 32'h1);
    pls(di_stop_i);
    $display("t_in_modes done");
  endtask : t_in_modes
  // Source moves to its next sample after each input acknowledge
  always @(posedge mclk_i) if (hs && di_ack_o) di_data_i <= di_data_i + 32'h1;
  initial begin
    cyc(4);
    srst_i = 1'h0;
    for (int i = 0; i < 64; i++) hm.mem[i] = 32'ha5000000 + i;
    t_out_pace;
    t_out_req;
    t_in_pace;
    t_in_ring;
    t_in_modes;
    finish_test;
  end
endmodule : testbench
`default_nettype wire
